// >>> hdl/a20_device.sv
// a20 gate, host a20 sequence decoder, fast reset port and alternate reset pulse
// Function
// - assist enable selects firmware latch for gate
// - firmware bit 0 write sets firmware latch
// - firmware a20 register upper bits read zero
// - readback shows selected latch; latches separate
// - D1 then data copies bit 1
// - recognised sequence never raises input full
// - address bit 2 high command; data bit1
// - D1+DF on, D1+DD off, FF silent
// - double D1 before data also accepted
// - other command after D1 passes through
// - extra data byte flags firmware, decoder idles
// - set and clear strobes move host latch
// - firmware confirms strobes by reading back while assist is off
// - NAND alternate and keyboard reset pulses
// - new pulse needs request bit cleared first
// - clear and reset during pulse adds nothing
// - fast reset port resets to zero
// - port disabled: writes ignored, reads float
// - reserved port bits ignored, read zero
// - port bit1 ORed into a20 gate output
// - request bit: 14 us delay, 6 us pulse
// - host write loads command flag, sets full
`timescale 1ns/10ps
`include "a20_map.svh"
module a20_device
  import a20_pkg::*;
(
  input wire logic ref_clk, // 50 mhz clock
  input wire logic resetn, // asynchronous reset, standby power-on
  a20_if.device bus, // host isa and firmware buses
  input wire logic firmware_assist_enable, // firmware drives the gate
  input wire logic fast_reset_port_enable, // fast reset port reachable
  input wire logic reset_out, // system reset output asserted
  input wire logic kbd_reset_pulse_n, // keyboard reset pulse, active low
  output logic a20_gate_output, // final a20 gate
  output logic cpu_reset_drive, // host cpu reset drive, active high
  output logic alt_reset_pulse_n, // internal alternate reset, active low
  output logic input_full_flag, // input buffer full to firmware
  output logic cmd_data_flag, // last host byte was a command
  output logic [7:0] input_data // last host byte passed to firmware
);

  dev_state_type s;
  dev_state_type next_s;

  logic kbd_wr;
  logic sa2;
  logic suppress;
  logic fw_read_in;
  logic kbc_a20;

  always_comb begin
    next_s = s;
    sa2 = bus.isa_addr[2];
    kbd_wr = bus.isa_wr &&
      (bus.isa_addr == `KBD_DATA_PORT || bus.isa_addr == `KBD_CMD_PORT);
    suppress = 1'b0;
    fw_read_in = bus.fw_rd && bus.fw_addr == `FW_KBD_IO_ADDR;
    kbc_a20 = firmware_assist_enable ? s.fw_latch : s.host_latch;

    // host sequence decoder only watches while firmware assist is off
    if (kbd_wr && !firmware_assist_enable) begin
      case (s.seq)
        seq_idle: begin
          if (sa2 && bus.isa_wdata == `A20_CMD_BYTE) begin
            next_s.seq = seq_cmd;
            suppress = 1'b1;
          end
        end
        seq_cmd: begin
          if (!sa2) begin
            next_s.host_latch = bus.isa_wdata[1];
            next_s.seq = seq_data;
            suppress = 1'b1;
          end else if (bus.isa_wdata == `A20_CMD_BYTE) begin
            suppress = 1'b1;
          end else begin
            next_s.seq = seq_idle;
          end
        end
        seq_data: begin
          next_s.seq = seq_idle;
          if (sa2 && bus.isa_wdata == `A20_END_CMD_BYTE) begin
            suppress = 1'b1;
          end else if (sa2 && bus.isa_wdata == `A20_CMD_BYTE) begin
            // a fresh D1 without the closing FF opens the next sequence
            next_s.seq = seq_cmd;
            suppress = 1'b1;
          end
          // a second data byte falls through unsuppressed and sets full
        end
        default: begin
          next_s.seq = seq_idle;
        end
      endcase
    end

    // firmware read of the input register empties it; a host write in the same cycle wins
    if (fw_read_in) begin
      next_s.input_full = 1'b0;
    end
    if (kbd_wr && !suppress) begin
      next_s.input_full = 1'b1;
      next_s.cmd_data = sa2;
      next_s.input_data = bus.isa_wdata;
    end

    // firmware writes; strobes come after the decoder so firmware wins a clash
    if (bus.fw_wr) begin
      case (bus.fw_addr)
        `FW_A20_ADDR: next_s.fw_latch = bus.fw_wdata[0];
        `FW_A20_SET_ADDR: next_s.host_latch = 1'b1;
        `FW_A20_CLEAR_ADDR: next_s.host_latch = 1'b0;
        default: next_s.fw_latch = s.fw_latch;
      endcase
    end

    // firmware read data, registered
    next_s.fw_rdata = 8'h00;
    if (bus.fw_rd) begin
      case (bus.fw_addr)
        `FW_A20_ADDR: next_s.fw_rdata = {7'h00, kbc_a20};
        `FW_KBD_IO_ADDR: next_s.fw_rdata = s.input_data;
        `FW_KBD_STATUS_ADDR: begin
          next_s.fw_rdata[`STATUS_IBF_BIT] = s.input_full;
          next_s.fw_rdata[`STATUS_CD_BIT] = s.cmd_data;
        end
        default: next_s.fw_rdata = 8'h00;
      endcase
    end

    // fast reset port
    if (reset_out) begin
      next_s.port = `FAST_RESET_PORT_RESET;
    end else if (fast_reset_port_enable && bus.isa_wr &&
                 bus.isa_addr == `FAST_RESET_PORT) begin
      next_s.port = bus.isa_wdata[1:0];
    end
    next_s.isa_rdata = 8'h00;
    next_s.isa_oe = 1'b0;
    if (fast_reset_port_enable && bus.isa_rd && bus.isa_addr == `FAST_RESET_PORT) begin
      next_s.isa_rdata = {6'h00, s.port};
      next_s.isa_oe = 1'b1;
    end

    // alternate reset pulse; rearming only in idle keeps a clear/set during a pulse silent
    case (s.rphase)
      rst_idle: begin
        if (s.port[0] && s.armed) begin
          next_s.rphase = rst_delay;
          next_s.rcount = 10'(`ALT_RST_DELAY_CYC - 1);
          next_s.armed = 1'b0;
        end else if (!s.port[0]) begin
          next_s.armed = 1'b1;
        end
      end
      rst_delay: begin
        if (s.rcount == 10'h000) begin
          next_s.rphase = rst_pulse;
          next_s.rcount = 10'(`ALT_RST_PULSE_CYC - 1);
        end else begin
          next_s.rcount = s.rcount - 10'h001;
        end
      end
      rst_pulse: begin
        if (s.rcount == 10'h000) begin
          next_s.rphase = rst_idle;
        end else begin
          next_s.rcount = s.rcount - 10'h001;
        end
      end
      default: begin
        next_s.rphase = rst_idle;
      end
    endcase

    next_s.alt_n = next_s.rphase != rst_pulse;
    next_s.cpu_reset = ~(next_s.alt_n & kbd_reset_pulse_n);
    next_s.a20 = (firmware_assist_enable ? next_s.fw_latch : next_s.host_latch)
      | next_s.port[1];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.seq <= seq_idle;
      s.rphase <= rst_idle;
      s.host_latch <= `HOST_A20_RESET;
      s.fw_latch <= `FW_A20_RESET;
      s.port <= `FAST_RESET_PORT_RESET;
      s.armed <= 1'b1;
      s.alt_n <= 1'b1;
      s.a20 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign a20_gate_output = s.a20;
  assign cpu_reset_drive = s.cpu_reset;
  assign alt_reset_pulse_n = s.alt_n;
  assign input_full_flag = s.input_full;
  assign cmd_data_flag = s.cmd_data;
  assign input_data = s.input_data;
  assign bus.isa_rdata = s.isa_rdata;
  assign bus.isa_rdata_oe = s.isa_oe;
  assign bus.fw_rdata = s.fw_rdata;

endmodule

// >>> hdl/a20_map.svh
// constants for the a20 gate and fast cpu reset logic
`ifndef A20_MAP_SVH
`define A20_MAP_SVH

// host isa i/o addresses; bit 2 of the address selects command versus data
`define KBD_DATA_PORT 16'h0060
`define KBD_CMD_PORT 16'h0064
`define FAST_RESET_PORT 16'h0092

// firmware memory-mapped addresses
`define FW_KBD_IO_ADDR 16'h7FF1
`define FW_KBD_STATUS_ADDR 16'h7FF2
`define FW_AUX_DATA_ADDR 16'h7FFA
`define FW_A20_ADDR 16'h7FFB
`define FW_A20_SET_ADDR 16'h7FFE
`define FW_A20_CLEAR_ADDR 16'h7FFF

// keyboard controller command bytes
`define A20_CMD_BYTE 8'hD1
`define A20_END_CMD_BYTE 8'hFF

// status bit positions seen by firmware at the status address
`define STATUS_IBF_BIT 1
`define STATUS_CD_BIT 3

// reset values
`define FAST_RESET_PORT_RESET 2'h0
`define FW_A20_RESET 1'h1
`define HOST_A20_RESET 1'h1

// alternate reset timing at the 50 mhz reference clock
`define CLK_MHZ 50
`define ALT_RST_DELAY_US 14
`define ALT_RST_PULSE_US 6
`define ALT_RST_DELAY_CYC (`ALT_RST_DELAY_US * `CLK_MHZ)
`define ALT_RST_PULSE_CYC (`ALT_RST_PULSE_US * `CLK_MHZ)
`define ALT_RST_CNT_W 10

// controller avalon register byte offsets and field bit positions
`define CTL_CMD_OFFSET 4'h0
`define CTL_STATUS_OFFSET 4'h4
`define CTL_CMD_ADDR_LSB 0
`define CTL_CMD_DATA_LSB 16
`define CTL_CMD_READ_BIT 24
`define CTL_CMD_FW_BIT 25
`define CTL_STATUS_OE_BIT 8
`define CTL_STATUS_BUSY_BIT 9

`endif

// >>> hdl/a20_pkg.sv
// types for the a20 gate and fast cpu reset logic
package a20_pkg;

  typedef enum logic [1:0] {seq_idle, seq_cmd, seq_data} seq_state_type;

  typedef enum logic [1:0] {rst_idle, rst_delay, rst_pulse} rst_state_type;

  typedef enum logic [1:0] {ctl_idle, ctl_strobe, ctl_capture} ctl_phase_type;

  typedef struct packed {
    seq_state_type seq;
    logic host_latch;
    logic fw_latch;
    logic [1:0] port;
    logic input_full;
    logic cmd_data;
    logic [7:0] input_data;
    rst_state_type rphase;
    logic armed;
    logic [9:0] rcount;
    logic alt_n;
    logic cpu_reset;
    logic a20;
    logic [7:0] isa_rdata;
    logic isa_oe;
    logic [7:0] fw_rdata;
  } dev_state_type;

  typedef struct packed {
    ctl_phase_type phase;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic fw;
    logic [7:0] rdata;
    logic oe;
    logic rd_ack;
    logic [31:0] readdata;
  } ctl_state_type;

endpackage

// >>> hdl/a20_if.sv
// host isa bus and firmware bus between controller and a20 device
`timescale 1ns/10ps
interface a20_if;
  logic [15:0] isa_addr;
  logic [7:0] isa_wdata;
  logic isa_wr;
  logic isa_rd;
  logic [7:0] isa_rdata;
  logic isa_rdata_oe;
  logic [15:0] fw_addr;
  logic [7:0] fw_wdata;
  logic fw_wr;
  logic fw_rd;
  logic [7:0] fw_rdata;

  modport device (
    input isa_addr, isa_wdata, isa_wr, isa_rd, fw_addr, fw_wdata, fw_wr, fw_rd,
    output isa_rdata, isa_rdata_oe, fw_rdata
  );

  modport controller (
    output isa_addr, isa_wdata, isa_wr, isa_rd, fw_addr, fw_wdata, fw_wr, fw_rd,
    input isa_rdata, isa_rdata_oe, fw_rdata
  );
endinterface

// >>> hdl/a20_controller.sv
// controller that plays host cpu and firmware, driven over avalon-mm
`timescale 1ns/10ps
`include "a20_map.svh"
module a20_controller
  import a20_pkg::*;
(
  input wire logic ref_clk, // 50 mhz clock
  input wire logic resetn, // asynchronous reset, active low
  a20_if.controller bus, // host isa and firmware buses
  input wire logic [3:0] avs_address, // avalon byte address
  input wire logic avs_read, // avalon read
  input wire logic avs_write, // avalon write
  input wire logic [31:0] avs_writedata, // avalon write data
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest // avalon wait request
);

  ctl_state_type s;
  ctl_state_type next_s;

  logic busy;

  always_comb begin
    next_s = s;
    busy = s.phase != ctl_idle;

    case (s.phase)
      ctl_idle: begin
        // a new command is taken only when idle; otherwise waitrequest holds the master
        if (avs_write && avs_address == `CTL_CMD_OFFSET) begin
          next_s.addr = avs_writedata[`CTL_CMD_ADDR_LSB +: 16];
          next_s.wdata = avs_writedata[`CTL_CMD_DATA_LSB +: 8];
          next_s.rd = avs_writedata[`CTL_CMD_READ_BIT];
          next_s.fw = avs_writedata[`CTL_CMD_FW_BIT];
          next_s.phase = ctl_strobe;
        end
      end
      ctl_strobe: begin
        next_s.phase = ctl_capture;
      end
      ctl_capture: begin
        if (s.rd) begin
          next_s.rdata = s.fw ? bus.fw_rdata : bus.isa_rdata;
          next_s.oe = s.fw ? 1'b1 : bus.isa_rdata_oe;
        end
        next_s.phase = ctl_idle;
      end
      default: begin
        next_s.phase = ctl_idle;
      end
    endcase

    // reads answer one cycle late from a registered copy
    next_s.rd_ack = 1'b0;
    if (avs_read && !s.rd_ack) begin
      next_s.rd_ack = 1'b1;
      case (avs_address)
        `CTL_CMD_OFFSET: next_s.readdata = {6'h00, s.fw, s.rd, s.wdata, s.addr};
        `CTL_STATUS_OFFSET: next_s.readdata = {22'h0, busy, s.oe, s.rdata};
        default: next_s.readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.phase <= ctl_idle;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest = (avs_write && s.phase != ctl_idle) || (avs_read && !s.rd_ack);
  assign avs_readdata = s.readdata;
  assign bus.isa_addr = s.addr;
  assign bus.isa_wdata = s.wdata;
  assign bus.isa_wr = s.phase == ctl_strobe && !s.fw && !s.rd;
  assign bus.isa_rd = s.phase == ctl_strobe && !s.fw && s.rd;
  assign bus.fw_addr = s.addr;
  assign bus.fw_wdata = s.wdata;
  assign bus.fw_wr = s.phase == ctl_strobe && s.fw && !s.rd;
  assign bus.fw_rd = s.phase == ctl_strobe && s.fw && s.rd;

endmodule

// >>> testbench/a20_properties.sv
// concurrent checks on the bus between controller and a20 device and on the device outputs
`timescale 1ns/10ps
module a20_properties (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset, active low
  input wire logic [15:0] isa_addr, // host address
  input wire logic [7:0] isa_wdata, // host write data
  input wire logic isa_wr, // host write
  input wire logic isa_rd, // host read
  input wire logic [7:0] isa_rdata, // host read data
  input wire logic isa_rdata_oe, // host read drive
  input wire logic [15:0] fw_addr, // firmware address
  input wire logic fw_wr, // firmware write
  input wire logic fw_rd, // firmware read
  input wire logic [7:0] fw_rdata, // firmware read data
  input wire logic firmware_assist_enable, // firmware owns gate
  input wire logic fast_reset_port_enable, // port reachable
  input wire logic kbd_reset_pulse_n, // keyboard reset
  input wire logic a20_gate_output, // gate
  input wire logic cpu_reset_drive, // cpu reset
  input wire logic alt_reset_pulse_n, // alternate reset
  input wire logic input_full_flag // input full
);
  int low_cnt;
  int gap_cnt;
  logic d1_seen;
  // gap restarts on every request write, so a write during a pulse never skews it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 0;
      gap_cnt <= 0;
      d1_seen <= 1'h0;
    end else begin
      low_cnt <= alt_reset_pulse_n ? 0 : low_cnt + 1;
      gap_cnt <= (isa_wr && isa_addr == 16'h0092 && fast_reset_port_enable && isa_wdata[0]) ?
        0 : gap_cnt + 1;
      if (isa_wr && (isa_addr == 16'h0060 || isa_addr == 16'h0064))
        d1_seen <= isa_addr == 16'h0064 && isa_wdata == 8'hD1 && !firmware_assist_enable;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence d1_cmd;
    isa_wr && isa_addr == 16'h0064 && isa_wdata == 8'hD1 && !firmware_assist_enable;
  endsequence
  sequence a20_data;
    isa_wr && isa_addr == 16'h0060 && d1_seen && !firmware_assist_enable;
  endsequence
  chk_seq_silent: assert property ((d1_cmd or a20_data) |=> (!$rose(input_full_flag)) [*2])
    else $error("input full raised in a20 sequence");
  chk_seq_latch: assert property (a20_data ##0 isa_wdata[1] |-> ##[1:2] a20_gate_output)
    else $error("a20 data byte did not set gate");
  chk_assist_full: assert property (isa_wr && firmware_assist_enable &&
    (isa_addr == 16'h0060 || isa_addr == 16'h0064) |=> ##[0:1] input_full_flag)
    else $error("host write did not set input full");
  chk_fw_upper: assert property (fw_rd && fw_addr == 16'h7FFB |=> fw_rdata[7:1] == 7'h00)
    else $error("a20 readback upper bits not zero");
  chk_port_off: assert property (isa_rd && isa_addr == 16'h0092 && !fast_reset_port_enable
    |=> !isa_rdata_oe)
    else $error("disabled port drove the bus");
  chk_port_rsvd: assert property (isa_rd && isa_addr == 16'h0092 && fast_reset_port_enable
    |=> isa_rdata_oe && isa_rdata[7:2] == 6'h00)
    else $error("port read wrong");
  chk_cpu_nand: assert property (cpu_reset_drive ==
    !(alt_reset_pulse_n && $past(kbd_reset_pulse_n)))
    else $error("cpu reset not nand of pulses");
  chk_pulse_width: assert property ($rose(alt_reset_pulse_n) |-> low_cnt == 300)
    else $error("alternate reset width wrong");
  chk_pulse_delay: assert property ($fell(alt_reset_pulse_n) |-> gap_cnt >= 700 &&
    gap_cnt <= 702)
    else $error("alternate reset delay wrong");
  chk_strobe_set: assert property (fw_wr && fw_addr == 16'h7FFE && !firmware_assist_enable
    |-> ##[1:2] a20_gate_output)
    else $error("set strobe did not raise gate");
  chk_alt_or: assert property (isa_wr && isa_addr == 16'h0092 && fast_reset_port_enable &&
    isa_wdata[1] |-> ##[1:2] a20_gate_output)
    else $error("port bit1 did not raise gate");
endmodule

// >>> testbench/a20_gate_and_fast_cpu_reset_tb.sv
// self-checking bench for the a20 controller and device pair
`timescale 1ns/10ps
module a20_gate_and_fast_cpu_reset_tb;
  typedef struct packed {
    logic [3:0] m; // assist, port enable, read, firmware bus
    logic [15:0] a;
    logic [7:0] d;
    logic [8:0] q; // drive flag and read data
    logic [1:0] gf; // gate, input full
  } row_type;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic firmware_assist_enable = 1'h0;
  logic fast_reset_port_enable = 1'h1;
  logic reset_out = 1'h0;
  logic kbd_reset_pulse_n = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic a20_gate_output, cpu_reset_drive, alt_reset_pulse_n, input_full_flag;
  int fails = 0;
  int cmp_count = 0;
  logic [8:0] q;
  logic cmd_data_flag;
  logic [7:0] input_data;
  logic [31:0] rd_word;
  int n;
  row_type rows [33] = '{
    '{4'h4,16'h0064,8'hD1,9'h000,2'h2}, '{4'h4,16'h0060,8'hDD,9'h000,2'h0},
    '{4'h4,16'h0064,8'hFF,9'h000,2'h0}, '{4'h4,16'h0064,8'hD1,9'h000,2'h0},
    '{4'h4,16'h0064,8'hD1,9'h000,2'h0}, '{4'h4,16'h0060,8'hDF,9'h000,2'h2},
    '{4'h4,16'h0064,8'hD1,9'h000,2'h2}, '{4'h4,16'h0064,8'hAB,9'h000,2'h3},
    '{4'h7,16'h7FF1,8'h00,9'h1AB,2'h2}, '{4'h4,16'h0064,8'hFF,9'h000,2'h3},
    '{4'h7,16'h7FF2,8'h00,9'h10A,2'h3},
    '{4'h7,16'h7FF1,8'h00,9'h1FF,2'h2}, '{4'h4,16'h0064,8'hD1,9'h000,2'h2},
    '{4'h4,16'h0060,8'hDD,9'h000,2'h0}, '{4'h4,16'h0060,8'hFF,9'h000,2'h1},
    '{4'h7,16'h7FF2,8'h00,9'h102,2'h1},
    '{4'h7,16'h7FF1,8'h00,9'h1FF,2'h0}, '{4'h5,16'h7FFE,8'h00,9'h000,2'h2},
    '{4'h7,16'h7FFB,8'h00,9'h101,2'h2}, '{4'h5,16'h7FFF,8'h5A,9'h000,2'h0},
    '{4'h7,16'h7FFB,8'h00,9'h100,2'h0}, '{4'h4,16'h0092,8'h02,9'h000,2'h2},
    '{4'h6,16'h0092,8'h00,9'h102,2'h2}, '{4'h4,16'h0092,8'hFC,9'h000,2'h0},
    '{4'h6,16'h0092,8'h00,9'h100,2'h0}, '{4'h0,16'h0092,8'h02,9'h000,2'h0},
    '{4'h2,16'h0092,8'h00,9'h000,2'h0}, '{4'hD,16'h7FFB,8'h00,9'h000,2'h0},
    '{4'hD,16'h7FFE,8'h00,9'h000,2'h0}, '{4'hF,16'h7FFB,8'h00,9'h100,2'h0},
    '{4'hC,16'h0064,8'hD1,9'h000,2'h1}, '{4'hF,16'h7FF1,8'h00,9'h1D1,2'h0},
    '{4'h7,16'h7FFB,8'h00,9'h101,2'h2}};
  a20_if a20_if_i ();
  a20_device a20_device_i (.ref_clk, .resetn, .bus(a20_if_i), .firmware_assist_enable,
    .fast_reset_port_enable, .reset_out, .kbd_reset_pulse_n, .a20_gate_output,
    .cpu_reset_drive, .alt_reset_pulse_n, .input_full_flag, .cmd_data_flag, .input_data);
  a20_controller a20_controller_i (.ref_clk, .resetn, .bus(a20_if_i), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  a20_properties a20_properties_i (.ref_clk, .resetn, .isa_addr(a20_if_i.isa_addr),
    .isa_wdata(a20_if_i.isa_wdata), .isa_wr(a20_if_i.isa_wr), .isa_rd(a20_if_i.isa_rd),
    .isa_rdata(a20_if_i.isa_rdata), .isa_rdata_oe(a20_if_i.isa_rdata_oe),
    .fw_addr(a20_if_i.fw_addr), .fw_wr(a20_if_i.fw_wr), .fw_rd(a20_if_i.fw_rd),
    .fw_rdata(a20_if_i.fw_rdata), .firmware_assist_enable, .fast_reset_port_enable,
    .kbd_reset_pulse_n, .a20_gate_output, .cpu_reset_drive, .alt_reset_pulse_n,
    .input_full_flag);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check_bit(input string s, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic check_word(input string s, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // the request stands until an edge samples waitrequest low; a hang is left to the watchdog
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    r = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic op(input row_type t, output logic [8:0] s);
    logic [31:0] r;
    av(1'h1, 4'h0, {6'h00, t.m[0], t.m[1], t.d, t.a}, r);
    do begin
      av(1'h0, 4'h4, 32'h0, r);
    end while (r[9] !== 1'h0);
    s = r[8:0];
  endtask
  task automatic wait_low(output int c);
    c = 0;
    while (alt_reset_pulse_n !== 1'h0 && c < 2000) begin
      @(negedge ref_clk);
      c++;
    end
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    resetn <= 1'h0;
    repeat (6) @(posedge ref_clk);
    check_word("reset outputs", 9'h00A, {5'h00, a20_gate_output, cpu_reset_drive,
      alt_reset_pulse_n, input_full_flag});
    resetn <= 1'h1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 33; i++) begin
      firmware_assist_enable <= rows[i].m[3];
      fast_reset_port_enable <= rows[i].m[2];
      op(rows[i], q);
      if (rows[i].m[1]) check_word("read data", rows[i].q, q);
      check_word("gate full", {7'h00, rows[i].gf}, {7'h00, a20_gate_output, input_full_flag});
    end
    check_word("host byte", 9'h1D1, {cmd_data_flag, input_data});
    av(1'h0, 4'h0, 32'h0, rd_word);
    check_bit("command readback", 1'h1, rd_word === 32'h03007FFB);
    $display("table done");
    op('{4'h4, 16'h0092, 8'h01, 9'h000, 2'h0}, q);
    wait_low(n);
    check_bit("alt delay", 1'h1, n > 640 && n < 702);
    n = 0;
    while (alt_reset_pulse_n === 1'h0 && n < 400) begin
      n++;
      @(negedge ref_clk);
      if (n == 2) check_bit("cpu reset", 1'h1, cpu_reset_drive);
    end
    check_bit("pulse width", 1'h1, n == 300);
    op('{4'h4, 16'h0092, 8'h00, 9'h000, 2'h0}, q);
    op('{4'h4, 16'h0092, 8'h01, 9'h000, 2'h0}, q);
    wait_low(n);
    check_bit("rearmed pulse", 1'h0, alt_reset_pulse_n);
    // clear and set again while the pulse still runs
    op('{4'h4, 16'h0092, 8'h00, 9'h000, 2'h0}, q);
    op('{4'h4, 16'h0092, 8'h01, 9'h000, 2'h0}, q);
    while (alt_reset_pulse_n === 1'h0) @(negedge ref_clk);
    wait_low(n);
    check_bit("no extra pulse", 1'h1, n == 2000);
    $display("alternate reset done");
    @(posedge ref_clk);
    kbd_reset_pulse_n <= 1'h0;
    @(negedge ref_clk);
    @(negedge ref_clk);
    check_bit("kbd cpu reset", 1'h1, cpu_reset_drive);
    @(posedge ref_clk);
    kbd_reset_pulse_n <= 1'h1;
    op('{4'h4, 16'h0092, 8'h02, 9'h000, 2'h0}, q);
    @(posedge ref_clk);
    reset_out <= 1'h1;
    @(posedge ref_clk);
    reset_out <= 1'h0;
    op('{4'h6, 16'h0092, 8'h00, 9'h000, 2'h0}, q);
    check_word("port after reset out", 9'h100, q);
    $display("reset inputs done");
    do_reset();
    op('{4'h7, 16'h7FFB, 8'h00, 9'h000, 2'h0}, q);
    check_word("a20 reg reset", 9'h101, q);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule
